// [hdl/cbm_defines.svh]
// Offsets, field positions, reset values and state counts of the block mover
`ifndef CBM_DEFINES_SVH
`define CBM_DEFINES_SVH
// ==========================================================================
// Register byte offsets
`define CBM_OFS_CTRL 8'h00
`define CBM_OFS_COUNT 8'h04
`define CBM_OFS_SRC 8'h08
`define CBM_OFS_DST 8'h0c
`define CBM_OFS_STATUS 8'h10
`define CBM_OFS_STATES 8'h14
`define CBM_OFS_OPA 8'h18
`define CBM_OFS_OPB 8'h1c
`define CBM_OFS_ALUOP 8'h20
`define CBM_OFS_CCR 8'h24
`define CBM_OFS_CYCLES 8'h28
`define CBM_OFS_SPER 8'h2c
`define CBM_OFS_EXEC 8'h30
// ==========================================================================
// Field positions
`define CBM_CTRL_START 0
`define CBM_CTRL_WORD 1
`define CBM_CCR_C 0
`define CBM_CCR_V 1
`define CBM_CCR_Z 2
`define CBM_CCR_N 3
`define CBM_CCR_H 5
`define CBM_CYC_ECLK 24
// ==========================================================================
// Reset values and state counts
`define CBM_RST_WORD 32'h0000_0000
`define CBM_MOVE_OVERHEAD 8
`define CBM_MOVE_PER_BYTE 4
`define CBM_PRE_LAST 2'h3
`define CBM_FETCH_ADDL_IMM 4'h3
`define CBM_FETCH_ADDL_REG 4'h1
`endif

// [hdl/cbm_pkg.sv]
// Types shared by the block mover and its flag unit
package cbm_pkg;
  // ========================================================================
  // Move engine states
  typedef enum {
    ST_IDLE, ST_PRE, ST_RD_A, ST_RD_B, ST_WR_A, ST_WR_B, ST_POST
  } cbm_state_e;
  // ========================================================================
  // Flag operations
  typedef enum logic [2:0] {
    OP_ADD_W, OP_SUB_W, OP_ADD_L, OP_SUB_L,
    OP_ADD_WITH_EXTEND, OP_DAA, OP_DIVN, OP_DIVQ
  } cbm_op_e;
  // ========================================================================
  // Carriers
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cbm_mem_s;
  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } cbm_flags_s;
endpackage : cbm_pkg

// [hdl/cbm_flag_unit.sv]
// Condition flag evaluation for arithmetic, adjust and divide operations
`timescale 1ns/100ps
module cbm_flag_unit (
  input wire cbm_pkg::cbm_op_e op,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire cbm_pkg::cbm_flags_s fin,
  output cbm_pkg::cbm_flags_s fout
);
  // ========================================================================
  // Flag computation, one operation per cycle
  always_comb begin
    logic [16:0] w;
    logic [12:0] h12;
    logic [32:0] l;
    logic [28:0] h28;
    logic [8:0] x;
    logic [4:0] h4;
    logic [7:0] adj;
    logic [31:0] mag_a;
    logic [15:0] mag_b;
    w = 17'h0;
    h12 = 13'h0;
    l = 33'h0;
    h28 = 29'h0;
    x = 9'h0;
    h4 = 5'h0;
    adj = 8'h0;
    mag_a = opa[31] ? 32'(-opa) : opa;
    mag_b = opb[15] ? 16'(-opb[15:0]) : opb[15:0];
    fout = fin;
    case (op)
      cbm_pkg::OP_ADD_W, cbm_pkg::OP_SUB_W: begin
        if (op == cbm_pkg::OP_ADD_W) begin
          w = {1'b0, opa[15:0]} + {1'b0, opb[15:0]};
          h12 = {1'b0, opa[11:0]} + {1'b0, opb[11:0]};
          fout.v = (opa[15] == opb[15]) && (w[15] != opa[15]);
        end else begin
          w = {1'b0, opa[15:0]} - {1'b0, opb[15:0]};
          h12 = {1'b0, opa[11:0]} - {1'b0, opb[11:0]};
          fout.v = (opa[15] != opb[15]) && (w[15] != opa[15]);
        end
        fout.h = h12[12];
        fout.n = w[15];
        fout.z = (w[15:0] == 16'h0);
        fout.c = w[16];
      end
      cbm_pkg::OP_ADD_L, cbm_pkg::OP_SUB_L: begin
        if (op == cbm_pkg::OP_ADD_L) begin
          l = {1'b0, opa} + {1'b0, opb};
          h28 = {1'b0, opa[27:0]} + {1'b0, opb[27:0]};
          fout.v = (opa[31] == opb[31]) && (l[31] != opa[31]);
        end else begin
          l = {1'b0, opa} - {1'b0, opb};
          h28 = {1'b0, opa[27:0]} - {1'b0, opb[27:0]};
          fout.v = (opa[31] != opb[31]) && (l[31] != opa[31]);
        end
        fout.h = h28[28];
        fout.n = l[31];
        fout.z = (l[31:0] == 32'h0);
        fout.c = l[32];
      end
      cbm_pkg::OP_ADD_WITH_EXTEND: begin
        x = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, fin.c};
        h4 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, fin.c};
        fout.h = h4[4];
        fout.n = x[7];
        fout.z = (x[7:0] == 8'h00) ? fin.z : 1'b0;
        fout.v = (opa[7] == opb[7]) && (x[7] != opa[7]);
        fout.c = x[8];
      end
      // decimal adjust sets carry or holds
      cbm_pkg::OP_DAA: begin
        if (opa[3:0] > 4'h9 || fin.h) begin
          adj[3:0] = 4'h6;
        end
        if (opa[7:4] > 4'h9 || fin.c ||
            (opa[7:4] == 4'h9 && opa[3:0] > 4'h9)) begin
          adj[7:4] = 4'h6;
        end
        x = {1'b0, opa[7:0]} + {1'b0, adj};
        fout.n = x[7];
        fout.z = (x[7:0] == 8'h00);
        fout.c = (adj[7:4] != 4'h0) ? 1'b1 : fin.c;
      end
      cbm_pkg::OP_DIVN: begin
        fout.n = opb[15];
        fout.z = (opb[15:0] == 16'h0);
      end
      cbm_pkg::OP_DIVQ: begin
        fout.n = (opb[15:0] != 16'h0) && (opa[31] ^ opb[15]) &&
                 (mag_a >= {16'h0, mag_b});
        fout.z = (opb[15:0] == 16'h0);
      end
      default: begin
        fout = fin;
      end
    endcase
  end
endmodule : cbm_flag_unit

// [hdl/cbm_core.sv]
// Block byte move engine, condition flags and state count unit on APB
//
// Operation
// - Byte form copies while low count nonzero
// - Word form uses full sixteen-bit count
// - Move takes eight plus four per byte
// - Word half carry from bit eleven
// - Longword half carry from bit twenty-seven
// - Extended add keeps zero, else clears
// - Adjust carry sets, else holds
// - E-clock transfers have no fixed count
// - Signed divide flags negative divisor
// - Division flags zero divisor
// - Division flags negative quotient
// - States are sum of counts times states
// - Long immediate add fetches three, register one
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "cbm_defines.svh"
module cbm_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cbm_pkg::cbm_mem_s mem,
  input wire logic [7:0] mem_rdata
);
  // ========================================================================
  // Helpers
  function automatic logic cnt_zero(input logic [15:0] c, input logic wd);
    cnt_zero = wd ? (c == 16'h0) : (c[7:0] == 8'h00);
  endfunction : cnt_zero

  function automatic logic [11:0] cyc(input logic [3:0] n,
                                      input logic [3:0] s);
    cyc = {8'h00, n} * {8'h00, s};
  endfunction : cyc

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `CBM_OFS_EXEC);
  endfunction : mapped

  // ========================================================================
  // State
  cbm_pkg::cbm_state_e state_r, state_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, word_r, word_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [15:0] cnt_r, cnt_nxt, src_r, src_nxt, dst_r, dst_nxt;
  logic [7:0] data_r, data_nxt;
  logic [19:0] states_r, states_nxt;
  logic [16:0] n0_r, n0_nxt;
  logic [31:0] opa_r, opa_nxt, opb_r, opb_nxt, cyc_r, cyc_nxt;
  logic [31:0] sper_r, sper_nxt, exec_r, exec_nxt;
  cbm_pkg::cbm_op_e op_r, op_nxt;
  logic alu_go_r, alu_go_nxt;
  cbm_pkg::cbm_flags_s ccr_r, ccr_nxt, flag_out;
  cbm_pkg::cbm_mem_s mem_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic wr_en, setup;

  assign setup = psel && !penable && !pready;
  // Writes land only at the access edge that pready completes
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // ========================================================================
  // Flag unit, evaluated the cycle after an operation write
  cbm_flag_unit u_flags (
    .op(op_r),
    .opa(opa_r),
    .opb(opb_r),
    .fin(ccr_r),
    .fout(flag_out)
  );

  // ========================================================================
  // APB answer: one wait-free access phase, error on unmapped offsets
  always_comb begin
    prdata_nxt = prdata;
    pready_nxt = setup;
    pslverr_nxt = setup && !mapped(paddr);
    if (setup) begin
      prdata_nxt = 32'h0;
      case (paddr)
        `CBM_OFS_CTRL: prdata_nxt = {30'h0, word_r, 1'b0};
        `CBM_OFS_COUNT: prdata_nxt = {16'h0, cnt_r};
        `CBM_OFS_SRC: prdata_nxt = {16'h0, src_r};
        `CBM_OFS_DST: prdata_nxt = {16'h0, dst_r};
        `CBM_OFS_STATUS: prdata_nxt = {29'h0, word_r, done_r, busy_r};
        `CBM_OFS_STATES: prdata_nxt = {12'h0, states_r};
        `CBM_OFS_OPA: prdata_nxt = opa_r;
        `CBM_OFS_OPB: prdata_nxt = opb_r;
        `CBM_OFS_ALUOP: prdata_nxt = {29'h0, op_r};
        `CBM_OFS_CCR: prdata_nxt = {26'h0, ccr_r.h, 1'b0, ccr_r.n,
                                    ccr_r.z, ccr_r.v, ccr_r.c};
        `CBM_OFS_CYCLES: prdata_nxt = cyc_r;
        `CBM_OFS_SPER: prdata_nxt = sper_r;
        `CBM_OFS_EXEC: prdata_nxt = exec_r;
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `CBM_RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ========================================================================
  // Operand, flag and state count registers
  always_comb begin
    logic [3:0] fetch;
    fetch = cyc_r[3:0];
    opa_nxt = opa_r;
    opb_nxt = opb_r;
    op_nxt = op_r;
    cyc_nxt = cyc_r;
    sper_nxt = sper_r;
    alu_go_nxt = 1'b0;
    ccr_nxt = ccr_r;
    // flags are frozen while a move runs
    if (alu_go_r) begin
      ccr_nxt = flag_out;
    end
    if (wr_en && !busy_r) begin
      case (paddr)
        `CBM_OFS_OPA: opa_nxt = pwdata;
        `CBM_OFS_OPB: opb_nxt = pwdata;
        `CBM_OFS_ALUOP: begin
          op_nxt = cbm_pkg::cbm_op_e'(pwdata[2:0]);
          alu_go_nxt = 1'b1;
        end
        `CBM_OFS_CCR: begin
          ccr_nxt.h = pwdata[`CBM_CCR_H];
          ccr_nxt.n = pwdata[`CBM_CCR_N];
          ccr_nxt.z = pwdata[`CBM_CCR_Z];
          ccr_nxt.v = pwdata[`CBM_CCR_V];
          ccr_nxt.c = pwdata[`CBM_CCR_C];
        end
        `CBM_OFS_CYCLES: cyc_nxt = {5'h0, pwdata[26:0]};
        `CBM_OFS_SPER: sper_nxt = {8'h0, pwdata[23:0]};
        default: ;
      endcase
    end
    // long add form fixes the fetch count
    if (cyc_r[26:25] == 2'h1) begin
      fetch = `CBM_FETCH_ADDL_IMM;
    end else if (cyc_r[26:25] == 2'h2) begin
      fetch = `CBM_FETCH_ADDL_REG;
    end
    // sum of cycle counts times states per cycle
    exec_nxt = {8'h0, fetch, 8'h0, cyc(fetch, sper_r[3:0]) +
                cyc(cyc_r[7:4], sper_r[7:4]) +
                cyc(cyc_r[11:8], sper_r[11:8]) +
                cyc(cyc_r[15:12], sper_r[15:12]) +
                cyc(cyc_r[19:16], sper_r[19:16]) +
                cyc(cyc_r[23:20], sper_r[23:20])};
    // E-clock transfer: count reads zero, variable bit set
    if (cyc_r[`CBM_CYC_ECLK]) begin
      exec_nxt = {1'b1, 7'h0, fetch, 20'h0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_r <= `CBM_RST_WORD;
      opb_r <= `CBM_RST_WORD;
      op_r <= cbm_pkg::OP_ADD_W;
      cyc_r <= `CBM_RST_WORD;
      sper_r <= `CBM_RST_WORD;
      exec_r <= `CBM_RST_WORD;
      alu_go_r <= 1'b0;
      ccr_r <= '0;
    end else begin
      opa_r <= opa_nxt;
      opb_r <= opb_nxt;
      op_r <= op_nxt;
      cyc_r <= cyc_nxt;
      sper_r <= sper_nxt;
      exec_r <= exec_nxt;
      alu_go_r <= alu_go_nxt;
      ccr_r <= ccr_nxt;
    end
  end

  // ========================================================================
  // move engine: 4 lead, 4 per byte, 4 trailing
  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    word_nxt = word_r;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    data_nxt = data_r;
    n0_nxt = n0_r;
    states_nxt = busy_r ? states_r + 20'h1 : states_r;
    case (state_r)
      cbm_pkg::ST_IDLE: begin
        if (wr_en) begin
          case (paddr)
            `CBM_OFS_COUNT: cnt_nxt = pwdata[15:0];
            `CBM_OFS_SRC: src_nxt = pwdata[15:0];
            `CBM_OFS_DST: dst_nxt = pwdata[15:0];
            `CBM_OFS_CTRL: begin
              word_nxt = pwdata[`CBM_CTRL_WORD];
              if (pwdata[`CBM_CTRL_START]) begin
                state_nxt = cbm_pkg::ST_PRE;
                busy_nxt = 1'b1;
                done_nxt = 1'b0;
                states_nxt = 20'h0;
                phase_nxt = 2'h0;
                n0_nxt = pwdata[`CBM_CTRL_WORD] ? {1'b0, cnt_r} :
                         {9'h0, cnt_r[7:0]};
              end
            end
            default: ;
          endcase
        end
      end
      cbm_pkg::ST_PRE: begin
        phase_nxt = phase_r + 2'h1;
        if (phase_r == `CBM_PRE_LAST) begin
          // zero count skips the copy loop
          state_nxt = cnt_zero(cnt_r, word_r) ? cbm_pkg::ST_POST :
                      cbm_pkg::ST_RD_A;
        end
      end
      cbm_pkg::ST_RD_A: state_nxt = cbm_pkg::ST_RD_B;
      cbm_pkg::ST_RD_B: begin
        data_nxt = mem_rdata;
        state_nxt = cbm_pkg::ST_WR_A;
      end
      cbm_pkg::ST_WR_A: state_nxt = cbm_pkg::ST_WR_B;
      cbm_pkg::ST_WR_B: begin
        src_nxt = src_r + 16'h1;
        dst_nxt = dst_r + 16'h1;
        // byte form decrements only the low byte
        // word form decrements all sixteen bits
        cnt_nxt = word_r ? cnt_r - 16'h1 :
                  {cnt_r[15:8], cnt_r[7:0] - 8'h01};
        state_nxt = cnt_zero(cnt_nxt, word_r) ? cbm_pkg::ST_POST :
                    cbm_pkg::ST_RD_A;
        phase_nxt = 2'h0;
      end
      cbm_pkg::ST_POST: begin
        phase_nxt = phase_r + 2'h1;
        if (phase_r == `CBM_PRE_LAST) begin
          state_nxt = cbm_pkg::ST_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      default: state_nxt = cbm_pkg::ST_IDLE;
    endcase
    // Bus request is registered so it lines up with the state it serves
    mem_nxt.req = (state_nxt == cbm_pkg::ST_RD_A) ||
                  (state_nxt == cbm_pkg::ST_WR_A);
    mem_nxt.we = (state_nxt == cbm_pkg::ST_WR_A);
    mem_nxt.addr = (state_nxt == cbm_pkg::ST_WR_A) ? dst_nxt : src_nxt;
    mem_nxt.wdata = data_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cbm_pkg::ST_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      word_r <= 1'b0;
      phase_r <= 2'h0;
      cnt_r <= 16'h0;
      src_r <= 16'h0;
      dst_r <= 16'h0;
      data_r <= 8'h00;
      n0_r <= 17'h0;
      states_r <= 20'h0;
      mem <= '0;
    end else begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      word_r <= word_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      data_r <= data_nxt;
      n0_r <= n0_nxt;
      states_r <= states_nxt;
      mem <= mem_nxt;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_copy;
    state_r == cbm_pkg::ST_RD_A ##1 state_r == cbm_pkg::ST_RD_B ##1
    state_r == cbm_pkg::ST_WR_A ##1 state_r == cbm_pkg::ST_WR_B;
  endsequence

  sequence s_read_then_write;
    mem.req && !mem.we ##2 mem.req && mem.we;
  endsequence

  // read then write of one byte
  AST_COPY_STEP: assert property (
    state_r == cbm_pkg::ST_RD_A |-> s_copy and s_read_then_write)
    else $error("Byte copy steps out of order");

  AST_MOVE_STATES: assert property (
    $fell(busy_r) |-> states_r ==
      20'(`CBM_MOVE_OVERHEAD) + 20'(`CBM_MOVE_PER_BYTE) * n0_r[15:0]
      + 20'(`CBM_MOVE_PER_BYTE) * {3'h0, n0_r[16], 16'h0})
    else $error("Move state count wrong");

  // byte form leaves high count byte alone
  AST_BYTE_HIGH: assert property (
    busy_r && !word_r |=> $stable(cnt_r[15:8]))
    else $error("High count byte changed in byte form");

  // source pointer advances and word count drops per byte
  AST_WORD_DEC: assert property (
    state_r == cbm_pkg::ST_WR_B && word_r |=>
      cnt_r == $past(cnt_r) - 16'h1 && src_r == $past(src_r) + 16'h1)
    else $error("Word count or pointer step wrong");

  // flags stay put and count ends at zero
  AST_MOVE_END: assert property (
    $fell(busy_r) |-> cnt_zero(cnt_r, word_r) &&
      dst_r == $past(dst_r, 4) && src_r == $past(src_r, 4) &&
      $stable(ccr_r))
    else $error("Move ended with count or flags wrong");

  // word half carry out of bit eleven
  AST_H_WORD: assert property (
    alu_go_r && op_r == cbm_pkg::OP_ADD_W |=> ccr_r.h ==
      ({1'b0, $past(opa_r[11:0])} + {1'b0, $past(opb_r[11:0])} > 13'hfff))
    else $error("Word half carry wrong");

  // longword half borrow out of bit twenty-seven
  AST_H_LONG: assert property (
    alu_go_r && op_r == cbm_pkg::OP_SUB_L |=> ccr_r.h ==
      ($past(opa_r[27:0]) < $past(opb_r[27:0])))
    else $error("Longword half carry wrong");

  AST_ADD_WITH_EXTEND_Z: assert property (
    alu_go_r && op_r == cbm_pkg::OP_ADD_WITH_EXTEND && !ccr_r.z |=> !ccr_r.z)
    else $error("Extended add set the zero flag");

  AST_DAA_C: assert property (
    alu_go_r && op_r == cbm_pkg::OP_DAA && ccr_r.c |=> ccr_r.c)
    else $error("Decimal adjust dropped carry");

  AST_DIV_ZERO: assert property (
    alu_go_r && (op_r == cbm_pkg::OP_DIVN || op_r == cbm_pkg::OP_DIVQ)
      |=> ccr_r.z == ($past(opb_r[15:0]) == 16'h0))
    else $error("Zero divisor flag wrong");
endmodule : cbm_core

// [verification/cbm_mem_model.sv]
// Byte memory on the far side of the mover, one cycle read latency
`timescale 1ns/100ps
module cbm_mem_model (
  input wire logic pclk,
  input wire cbm_pkg::cbm_mem_s mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:1023];
  logic [7:0] rd_r;
  // ==========================================================================
  // Preload with a pattern the bench can recompute
  initial begin
    for (int i = 0; i < 1024; i++) begin
      m[i] = i[7:0] ^ 8'ha5;
    end
    rd_r = 8'h00;
  end
  // Read data is good only in the cycle after a read; otherwise the line
  // toggles so a late sample never finds a stale byte
  always @(posedge pclk) begin
    if (mem.req && !mem.we) begin
      rd_r <= m[mem.addr[9:0]];
    end else begin
      rd_r <= ~rd_r;
    end
    if (mem.req && mem.we) begin
      m[mem.addr[9:0]] <= mem.wdata;
    end
  end
  assign mem_rdata = rd_r;
endmodule : cbm_mem_model

// [verification/tb_top.sv]
// Self-checking bench: APB tasks driving the mover, flags and state counter
`timescale 1ns/100ps
`include "cbm_defines.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, mem_rdata;
  logic [31:0] pwdata, prdata, q;
  cbm_pkg::cbm_mem_s mem;
  int n_errors, checks_done;
  // ==========================================================================
  // Design and memory partner
  cbm_core cbm_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem(mem),
    .mem_rdata(mem_rdata));
  cbm_mem_model cbm_mem_model_i (.pclk(pclk), .mem(mem),
    .mem_rdata(mem_rdata));
  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================================================
  // Verdict and helpers
  task end_sim;
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  function automatic logic [7:0] pat(input int a);
    return a[7:0] ^ 8'ha5;
  endfunction : pat
  // One APB transfer; an idle cycle follows so psel is never set twice
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, q & m)
  endtask : rc
  // Block move with a count write while busy, which must be ignored
  task mv(input logic [15:0] c, input logic w, input logic [15:0] s, d);
    int n, k;
    n = w ? int'(c) : int'(c[7:0]);
    wr(`CBM_OFS_CCR, 32'h0000_002b);
    wr(`CBM_OFS_COUNT, {16'h0, c});
    wr(`CBM_OFS_SRC, {16'h0, s});
    wr(`CBM_OFS_DST, {16'h0, d});
    wr(`CBM_OFS_CTRL, {30'h0, w, 1'b1});
    wr(`CBM_OFS_COUNT, 32'h0000_0077);
    k = 0;
    do begin
      apb(1'b0, `CBM_OFS_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 1000);
    `CHK("busy", 1'b0, q[0])
    rc("states", `CBM_OFS_STATES, '1, 32'(8 + 4 * n));
    rc("count", `CBM_OFS_COUNT, '1, {16'h0, w ? 8'h0 : c[15:8], 8'h0});
    rc("src", `CBM_OFS_SRC, '1, {16'h0, s + n[15:0]});
    rc("dst", `CBM_OFS_DST, '1, {16'h0, d + n[15:0]});
    rc("ccr", `CBM_OFS_CCR, '1, 32'h0000_002b);
    rc("status", `CBM_OFS_STATUS, 32'h7, {29'h0, w, 2'h2});
    for (k = 0; k < n; k++) begin
      `CHK("byte", pat(s + k), cbm_mem_model_i.m[d + k])
    end
    `CHK("beyond", pat(d + n), cbm_mem_model_i.m[d + n])
  endtask : mv
  // Flag evaluation: load flags and operands, start, read masked flags
  task fl(input logic [2:0] op, input logic [31:0] a, b,
          input logic [7:0] ci, m, e);
    wr(`CBM_OFS_CCR, {24'h0, ci});
    wr(`CBM_OFS_OPA, a);
    wr(`CBM_OFS_OPB, b);
    wr(`CBM_OFS_ALUOP, {29'h0, op});
    repeat (2) @(posedge pclk);
    rc("flags", `CBM_OFS_CCR, {24'h0, m}, {24'h0, e});
  endtask : fl
  task cy(input logic [31:0] c, sp, m, e);
    wr(`CBM_OFS_CYCLES, c);
    wr(`CBM_OFS_SPER, sp);
    rc("exec", `CBM_OFS_EXEC, m, e);
  endtask : cy
  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, err} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc("status", `CBM_OFS_STATUS, '1, 32'h0);
    rc("ccr", `CBM_OFS_CCR, '1, 32'h0);
    wr(`CBM_OFS_STATES, 32'h0000_0055);
    rc("states_ro", `CBM_OFS_STATES, '1, 32'h0);
    wr(8'h34, 32'h1);
    `CHK("err_wr", 1'b1, err)
    rc("unmapped", 8'h34, '1, 32'h0);
    `CHK("err_rd", 1'b1, err)
    rc("misaligned", 8'h06, '1, 32'h0);
    `CHK("err_al", 1'b1, err)
    $display("Test registers done");
    mv(16'h0103, 1'b0, 16'h0010, 16'h0080);
    mv(16'h0200, 1'b0, 16'h0100, 16'h0180);
    mv(16'h0102, 1'b1, 16'h0110, 16'h0240);
    mv(16'h0000, 1'b1, 16'h0300, 16'h0380);
    $display("Test moves done");
    fl(cbm_pkg::OP_ADD_W, 32'h0fff, 32'h1, 8'h00, 8'h20, 8'h20);
    fl(cbm_pkg::OP_ADD_W, 32'h0f00, 32'hff, 8'h20, 8'h20, 8'h00);
    fl(cbm_pkg::OP_SUB_W, 32'h1000, 32'h1, 8'h00, 8'h20, 8'h20);
    fl(cbm_pkg::OP_ADD_L, 32'h0fff_ffff, 32'h1, 8'h0, 8'h20, 8'h20);
    fl(cbm_pkg::OP_ADD_L, 32'h0fff, 32'h1, 8'h20, 8'h20, 8'h00);
    fl(cbm_pkg::OP_SUB_L, 32'h1000_0000, 32'h1, 8'h0, 8'h20, 8'h20);
    fl(cbm_pkg::OP_ADD_WITH_EXTEND, 32'h0, 32'h0, 8'h04, 8'h04, 8'h04);
    fl(cbm_pkg::OP_ADD_WITH_EXTEND, 32'h0, 32'h0, 8'h00, 8'h04, 8'h00);
    fl(cbm_pkg::OP_ADD_WITH_EXTEND, 32'h1, 32'h0, 8'h04, 8'h04, 8'h00);
    fl(cbm_pkg::OP_ADD_WITH_EXTEND, 32'hff, 32'h0, 8'h05, 8'h04, 8'h04);
    fl(cbm_pkg::OP_DAA, 32'h9a, 32'h0, 8'h00, 8'h01, 8'h01);
    fl(cbm_pkg::OP_DAA, 32'h12, 32'h0, 8'h01, 8'h01, 8'h01);
    fl(cbm_pkg::OP_DAA, 32'h12, 32'h0, 8'h00, 8'h01, 8'h00);
    fl(cbm_pkg::OP_DIVN, 32'h64, 32'h8000, 8'h00, 8'h0c, 8'h08);
    fl(cbm_pkg::OP_DIVN, 32'h64, 32'h5, 8'h0c, 8'h0c, 8'h00);
    fl(cbm_pkg::OP_DIVN, 32'h64, 32'h0, 8'h08, 8'h0c, 8'h04);
    fl(cbm_pkg::OP_DIVQ, 32'hffff_fff6, 32'h2, 8'h0, 8'h0c, 8'h08);
    fl(cbm_pkg::OP_DIVQ, 32'ha, 32'h2, 8'h08, 8'h0c, 8'h00);
    fl(cbm_pkg::OP_DIVQ, 32'ha, 32'h0, 8'h00, 8'h04, 8'h04);
    $display("Test flags done");
    cy(32'h0065_4321, 32'h0012_3456, '1, 32'h0010_0038);
    cy(32'h0000_2002, 32'h0022_2222, '1, 32'h0020_0008);
    cy(32'h0200_0000, 32'h0000_0002, '1, 32'h0030_0006);
    cy(32'h0400_0005, 32'h0000_0002, '1, 32'h0010_0002);
    cy(32'h0100_2002, 32'h0022_2222, 32'h8000_0fff, 32'h8000_0000);
    $display("Test state counts done");
    end_sim;
  end
  // Watchdog well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("Watchdog expired");
    end_sim;
  end
endmodule : tb_top
